// ==== tb/test_ssr_regs.sv ====
// Self-checking testbench of the subsystem, legacy base and system configuration register bank.
`timescale 1ns/1ps

`define CHK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", name, exp, got); end end

module test_ssr_regs;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk;
  logic        reset_n;
  logic        bus_reset_n;
  logic [10:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        eeprom_present;
  logic        eeprom_load_valid;
  logic [15:0] eeprom_subsys_vendor;
  logic [15:0] eeprom_subsys_id;
  logic        io_valid;
  logic [31:0] io_address;
  logic        legacy_index_hit;
  logic        legacy_data_hit;
  int          mismatches;
  int          n_compared;
  logic [31:0] rd;

  // Byte addresses of function 0; function 1 adds 0x400.
  localparam logic [10:0] A_VEN = 11'h100;
  localparam logic [10:0] A_SID = 11'h108;
  localparam logic [10:0] A_LEG = 11'h110;
  localparam logic [10:0] A_CFG = 11'h200;
  localparam logic [10:0] F1    = 11'h400;

  ssr_regs dut (
    .mclk                 (mclk),
    .reset_n              (reset_n),
    .bus_reset_n          (bus_reset_n),
    .avs_address          (avs_address),
    .avs_read             (avs_read),
    .avs_write            (avs_write),
    .avs_writedata        (avs_writedata),
    .avs_byteenable       (avs_byteenable),
    .avs_readdata         (avs_readdata),
    .avs_waitrequest      (avs_waitrequest),
    .eeprom_present       (eeprom_present),
    .eeprom_load_valid    (eeprom_load_valid),
    .eeprom_subsys_vendor (eeprom_subsys_vendor),
    .eeprom_subsys_id     (eeprom_subsys_id),
    .io_valid             (io_valid),
    .io_address           (io_address),
    .legacy_index_hit     (legacy_index_hit),
    .legacy_data_hit      (legacy_data_hit)
  );

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Bus and report tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Runs one transfer, holding it until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int i;
    @(posedge mclk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      mismatches++;
      $display("ERROR bus answer expected waitrequest low seen none");
      end_sim();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // Writes a register through the bus.
  task automatic wr(input logic [10:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  // Reads a register through the bus and compares it.
  task automatic rchk(input string nm, input logic [10:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    `CHK(nm, exp, q)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Checks reset values in both functions and an unmapped offset.
  task automatic t_defaults();
    for (int f = 0; f < 2; f++) begin
      rchk("vendor", A_VEN | (f ? F1 : 11'h000), 32'h0000_0000);
      rchk("subsys", A_SID | (f ? F1 : 11'h000), 32'h0000_0000);
      rchk("legacy", A_LEG | (f ? F1 : 11'h000), 32'h0000_0001);
      rchk("sysconfig", A_CFG | (f ? F1 : 11'h000), 32'h0000_0020);
    end
    wr(11'h004, 32'hffff_ffff, 4'hf);
    rchk("unmapped", 11'h004, 32'h0000_0000);
    $display("test defaults done");
  endtask

  // Locked writes are dropped, unlocked writes land, relocking freezes them again.
  task automatic t_lock();
    wr(A_VEN, 32'h0000_beef, 4'hf);
    rchk("locked vendor", A_VEN, 32'h0000_0000);
    wr(A_CFG, 32'h0000_0000, 4'h1);
    rchk("unlocked cfg", A_CFG, 32'h0000_0000);
    wr(A_VEN, 32'habcd_1234, 4'h3);
    wr(A_SID, 32'h0000_5678, 4'h1);
    rchk("vendor", A_VEN, 32'h0000_1234);
    rchk("subsys", A_SID, 32'h0000_0078);
    wr(A_VEN | F1, 32'h0000_1111, 4'hf);
    rchk("f1 vendor", A_VEN | F1, 32'h0000_0000);
    wr(A_CFG, 32'h0000_0020, 4'h1);
    wr(A_SID, 32'h0000_9999, 4'hf);
    rchk("relocked subsys", A_SID, 32'h0000_0078);
    $display("test lock done");
  endtask

  // Shared legacy base and the index and data decode.
  task automatic t_legacy();
    wr(A_LEG | F1, 32'h0000_03e0, 4'hf);
    rchk("legacy f0", A_LEG, 32'h0000_03e1);
    wr(A_LEG, 32'hffff_fffe, 4'hf);
    rchk("legacy f1", A_LEG | F1, 32'hffff_ffff);
    wr(A_LEG, 32'h0000_03e0, 4'hf);
    @(posedge mclk);
    io_valid   <= 1'b1;
    io_address <= 32'h0000_03e0;
    @(posedge mclk);
    io_address <= 32'h0000_03e1;
    @(negedge mclk);
    `CHK("index hit", 2'b10, {legacy_index_hit, legacy_data_hit})
    @(posedge mclk);
    io_address <= 32'h0000_03e2;
    @(negedge mclk);
    `CHK("data hit", 2'b01, {legacy_index_hit, legacy_data_hit})
    @(posedge mclk);
    io_valid <= 1'b0;
    @(negedge mclk);
    `CHK("no hit", 2'b00, {legacy_index_hit, legacy_data_hit})
    $display("test legacy done");
  endtask

  // Global bits are one copy, per-function bits are not.
  task automatic t_global();
    wr(A_CFG, 32'h3000_0000, 4'h8);
    rchk("cfg f0", A_CFG, 32'h3000_0020);
    rchk("cfg f1", A_CFG | F1, 32'h2000_0020);
    $display("test global done");
  endtask

  // Presents one loader pulse with the given values.
  task automatic t_load(input logic present, input logic [15:0] v, input logic [15:0] s);
    @(posedge mclk);
    eeprom_present       <= present;
    eeprom_subsys_vendor <= v;
    eeprom_subsys_id     <= s;
    eeprom_load_valid    <= 1'b1;
    @(posedge mclk);
    eeprom_load_valid <= 1'b0;
  endtask

  // Loads are dropped without a fitted memory and pass the lock in both functions with one.
  task automatic t_eeprom();
    t_load(1'b0, 16'h5a5a, 16'ha5a5);
    rchk("absent vendor", A_VEN, 32'h0000_1234);
    t_load(1'b1, 16'hc0de, 16'h7e57);
    for (int f = 0; f < 2; f++) begin
      rchk("load vendor", A_VEN | (f ? F1 : 11'h000), 32'h0000_c0de);
      rchk("load subsys", A_SID | (f ? F1 : 11'h000), 32'h0000_7e57);
    end
    $display("test eeprom done");
  endtask

  // Bus reset keeps marked bits, global reset clears them.
  task automatic t_resets();
    @(posedge mclk);
    bus_reset_n <= 1'b0;
    @(posedge mclk);
    bus_reset_n <= 1'b1;
    rchk("bus rst vendor", A_VEN, 32'h0000_c0de);
    rchk("bus rst legacy", A_LEG | F1, 32'h0000_03e1);
    rchk("bus rst cfg", A_CFG, 32'h2000_0020);
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    t_defaults();
    $display("test resets done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Drives time-zero values, resets the block and runs every scenario.
  initial begin
    mismatches           = 0;
    n_compared           = 0;
    reset_n              = 1'b0;
    bus_reset_n          = 1'b1;
    avs_address          = 11'h000;
    avs_read             = 1'b0;
    avs_write            = 1'b0;
    avs_writedata        = 32'h0000_0000;
    avs_byteenable       = 4'h0;
    eeprom_present       = 1'b0;
    eeprom_load_valid    = 1'b0;
    eeprom_subsys_vendor = 16'h0000;
    eeprom_subsys_id     = 16'h0000;
    io_valid             = 1'b0;
    io_address           = 32'h0000_0000;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    t_defaults();
    t_lock();
    t_legacy();
    t_global();
    t_eeprom();
    t_resets();
    end_sim();
  end

endmodule

// ==== verilog/ssr_id_reg.sv ====
// Lockable 16-bit identification register with a loader port.
`timescale 1ns/1ps

module ssr_id_reg (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic [1:0]  wr_be,
  input  wire logic        write_lock,
  input  wire logic        load_valid,
  input  wire logic [15:0] load_data,
  output logic      [15:0] value_q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // A load from the serial memory wins over a host write in the same cycle.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      value_q <= ssr_pkg::SUBSYS_RESET;
    end else if (load_valid) begin
      value_q <= load_data; // [R3]
    end else if (wr_en && !write_lock) begin // [R10]
      value_q <= 16'(ssr_pkg::ssr_merge({16'h0000, value_q}, {16'h0000, wr_data},
                                        {2'b00, wr_be}, ssr_pkg::SUBSYS_RW_MASK)); // [R1]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LOCKED_WRITE_IGNORED: assert property (@(posedge mclk) disable iff (!reset_n) // [R10]
    wr_en && write_lock && !load_valid |=> $stable(value_q))
    else $error("Locked identification register changed on a write.");

endmodule

// ==== verilog/ssr_legacy_decode.sv ====
// Decoder for the legacy socket index and data I/O addresses.
`timescale 1ns/1ps

module ssr_legacy_decode (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [31:0] base,
  input  wire logic        io_valid,
  input  wire logic [31:0] io_address,
  output logic             index_hit_q,
  output logic             data_hit_q
);

  logic [31:0] index_address;
  logic [31:0] data_address;

  // Bit zero of the base is a fixed flag, so the index port is the base with bit zero cleared.
  assign index_address = base & ~ssr_pkg::LEGACY_BASE_FIXED; // [R7]
  // The data port sits one above the index port.
  assign data_address  = 32'(index_address + ssr_pkg::LEGACY_DATA_OFFSET); // [R6]

  // Registered hits for the index and data ports.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      index_hit_q <= 1'b0;
      data_hit_q  <= 1'b0;
    end else begin
      index_hit_q <= io_valid && (io_address == index_address); // [R6]
      data_hit_q  <= io_valid && (io_address == data_address); // [R6]
    end
  end

  AST_DATA_PORT_PLUS_ONE: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
    io_valid && (io_address == 32'((base & ~ssr_pkg::LEGACY_BASE_FIXED) + ssr_pkg::LEGACY_DATA_OFFSET))
    |=> data_hit_q && !index_hit_q)
    else $error("Data port did not decode at base plus one.");

endmodule

// ==== verilog/ssr_pkg.sv ====
// Package with offsets, field layouts, reset values and helpers of the subsystem and system configuration registers.
package ssr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int                ADDR_W         = 11;
  localparam int                DATA_W         = 32;
  localparam int                BE_W           = 4;
  localparam int                FUNC_SEL_BIT   = 10;
  localparam int                IDX_SHIFT      = 2;
  localparam logic [ADDR_W-1:0] OFFSET_MASK    = 11'h3ff;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SUBSYS_VENDOR = 8'h40;
  localparam logic [7:0] IDX_SUBSYS_ID     = 8'h42;
  localparam logic [7:0] IDX_LEGACY_BASE   = 8'h44;
  localparam logic [7:0] IDX_SYS_CONFIG    = 8'h80;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SUBSYS_RESET       = 16'h0000;
  localparam logic [31:0] SUBSYS_RW_MASK     = 32'h0000_ffff;
  localparam logic [31:0] LEGACY_BASE_RESET  = 32'h0000_0001;
  localparam logic [31:0] LEGACY_BASE_FIXED  = 32'h0000_0001;
  localparam logic [31:0] LEGACY_RW_MASK     = 32'hffff_fffe;
  localparam logic [31:0] LEGACY_DATA_OFFSET = 32'h0000_0001;
  localparam logic [31:0] SYSCFG_RESET       = 32'h0000_0020;
  localparam logic [31:0] SYSCFG_RW_MASK     = 32'hff7f_c07b;
  localparam logic [31:0] SYSCFG_GLOBAL_MASK = 32'hed00_0000;
  localparam logic [31:0] SYSCFG_BUSRST_MASK = 32'h1000_0000;
  localparam int          WRITE_LOCK_BIT     = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } ssr_bus_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merges write data into an old value under byte enables and a writable mask.
  function automatic logic [31:0] ssr_merge(input logic [31:0] old_value,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be,
                                            input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = 32'h0000_0000;
    for (int i = 0; i < BE_W; i++) begin
      lanes[i*8 +: 8] = {8{be[i]}};
    end
    return (old_value & ~(lanes & mask)) | (wdata & lanes & mask);
  endfunction

  // Turns a register index into its byte address.
  function automatic logic [ADDR_W-1:0] ssr_byte_addr(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction

endpackage

// ==== verilog/ssr_regs.sv ====
// Subsystem identification, legacy socket base and system configuration registers on an Avalon-MM slave.
`timescale 1ns/1ps

// How it works
// [R1] Identification writes only while write lock clear.
// [R2] Reset sets write lock, identifications read-only.
// [R3] Serial memory loads both identifications after reset.
// [R4] Only global reset clears marked bits.
// [R5] Vendor at 40h, identification at 42h.
// [R6] Index at base, data at base plus one.
// [R7] Base anywhere, bit zero reads one.
// [R8] One legacy base shared by both functions.
// [R9] Global configuration bits kept as single copy.
// [R10] Locked identification writes ignored, value kept.
module ssr_regs (
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire logic                       bus_reset_n,
  input  wire logic [ssr_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       eeprom_present,
  input  wire logic                       eeprom_load_valid,
  input  wire logic [15:0]                eeprom_subsys_vendor,
  input  wire logic [15:0]                eeprom_subsys_id,
  input  wire logic                       io_valid,
  input  wire logic [31:0]                io_address,
  output logic                            legacy_index_hit,
  output logic                            legacy_data_hit
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ssr_pkg::ssr_bus_state_t      bus_state_q;
  logic                         req_func;
  logic [ssr_pkg::ADDR_W-1:0]   req_offset;
  logic                         hit_vendor;
  logic                         hit_subsys;
  logic                         hit_legacy;
  logic                         hit_syscfg;
  logic                         commit_write;
  logic                         load_now;
  logic [31:0]                  rd_value;
  logic [31:0]                  legacy_base_q;
  logic [31:0]                  sysctl_global_q;
  logic [31:0]                  sysctl_local_q [2];
  logic [15:0]                  vendor_val     [2];
  logic [15:0]                  subsys_val     [2];
  logic [1:0]                   write_lock;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // The function number is one address bit, the rest is the register offset.
  assign req_func   = avs_address[ssr_pkg::FUNC_SEL_BIT];
  assign req_offset = avs_address & ssr_pkg::OFFSET_MASK;
  assign hit_vendor = (req_offset == ssr_pkg::ssr_byte_addr(ssr_pkg::IDX_SUBSYS_VENDOR)); // [R5]
  assign hit_subsys = (req_offset == ssr_pkg::ssr_byte_addr(ssr_pkg::IDX_SUBSYS_ID)); // [R5]
  assign hit_legacy = (req_offset == ssr_pkg::ssr_byte_addr(ssr_pkg::IDX_LEGACY_BASE));
  assign hit_syscfg = (req_offset == ssr_pkg::ssr_byte_addr(ssr_pkg::IDX_SYS_CONFIG));

  // Writes take effect at the edge where the master sees waitrequest low; a bus reset then drops them.
  assign commit_write = (bus_state_q == ssr_pkg::BUS_ANSWER) && avs_write && bus_reset_n;

  // The loader is honoured only when a serial memory is fitted.
  assign load_now = eeprom_present && eeprom_load_valid; // [R3]

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Narrow registers sit in the low bits; unmapped offsets read as zero.
  always_comb begin
    rd_value = 32'h0000_0000;
    if (hit_vendor) begin
      rd_value = {16'h0000, vendor_val[req_func]}; // [R5]
    end else if (hit_subsys) begin
      rd_value = {16'h0000, subsys_val[req_func]}; // [R5]
    end else if (hit_legacy) begin
      rd_value = legacy_base_q; // [R8]
    end else if (hit_syscfg) begin
      rd_value = sysctl_global_q | sysctl_local_q[req_func]; // [R9]
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Every request is answered one cycle after it is first seen.
  always_ff @(posedge mclk) begin
    if (!reset_n || !bus_reset_n) begin
      bus_state_q     <= ssr_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state_q)
        ssr_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_q     <= ssr_pkg::BUS_ANSWER;
            avs_waitrequest <= 1'b0;
          end
        end
        ssr_pkg::BUS_ANSWER: begin
          bus_state_q     <= ssr_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state_q     <= ssr_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read data are captured when the answer is raised and held until the next read.
  always_ff @(posedge mclk) begin
    if (!reset_n || !bus_reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if ((bus_state_q == ssr_pkg::BUS_IDLE) && avs_read) begin
      avs_readdata <= rd_value;
    end
  end

  // ----------------------------------------------------------------
  // System configuration
  // ----------------------------------------------------------------
  // Global bits live once and are written through either function.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sysctl_global_q <= ssr_pkg::SYSCFG_RESET & ssr_pkg::SYSCFG_GLOBAL_MASK;
    end else if (commit_write && hit_syscfg) begin
      sysctl_global_q <= ssr_pkg::ssr_merge(sysctl_global_q, avs_writedata, avs_byteenable,
                                            ssr_pkg::SYSCFG_GLOBAL_MASK); // [R9]
    end
  end

  // Socket bits are kept per function; bus reset clears only the unmarked bit.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int f = 0; f < 2; f++) begin
        sysctl_local_q[f] <= ssr_pkg::SYSCFG_RESET & ~ssr_pkg::SYSCFG_GLOBAL_MASK; // [R2]
      end
    end else begin
      for (int f = 0; f < 2; f++) begin
        if (!bus_reset_n) begin
          sysctl_local_q[f] <= sysctl_local_q[f] & ~ssr_pkg::SYSCFG_BUSRST_MASK; // [R4]
        end else if (commit_write && hit_syscfg && (req_func == 1'(f))) begin
          sysctl_local_q[f] <= ssr_pkg::ssr_merge(sysctl_local_q[f], avs_writedata, avs_byteenable,
                                                  ssr_pkg::SYSCFG_RW_MASK & ~ssr_pkg::SYSCFG_GLOBAL_MASK);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Legacy socket base
  // ----------------------------------------------------------------
  // One shared copy; bit zero is forced to one on every write.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      legacy_base_q <= ssr_pkg::LEGACY_BASE_RESET;
    end else if (commit_write && hit_legacy) begin
      legacy_base_q <= ssr_pkg::ssr_merge(legacy_base_q, avs_writedata, avs_byteenable,
                                          ssr_pkg::LEGACY_RW_MASK) | ssr_pkg::LEGACY_BASE_FIXED; // [R7] [R8]
    end
  end

  ssr_legacy_decode u_legacy_decode (
    .mclk        (mclk),
    .reset_n     (reset_n),
    .base        (legacy_base_q),
    .io_valid    (io_valid),
    .io_address  (io_address),
    .index_hit_q (legacy_index_hit),
    .data_hit_q  (legacy_data_hit)
  );

  // ----------------------------------------------------------------
  // Subsystem identification, one pair per function
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_func
    // The lock bit of each function guards that function's pair.
    assign write_lock[g] = sysctl_local_q[g][ssr_pkg::WRITE_LOCK_BIT]; // [R1]

    ssr_id_reg u_vendor (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .wr_en      (commit_write && hit_vendor && (req_func == 1'(g))),
      .wr_data    (avs_writedata[15:0]),
      .wr_be      (avs_byteenable[1:0]),
      .write_lock (write_lock[g]),
      .load_valid (load_now),
      .load_data  (eeprom_subsys_vendor),
      .value_q    (vendor_val[g])
    );

    ssr_id_reg u_subsys (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .wr_en      (commit_write && hit_subsys && (req_func == 1'(g))),
      .wr_data    (avs_writedata[15:0]),
      .wr_be      (avs_byteenable[1:0]),
      .write_lock (write_lock[g]),
      .load_valid (load_now),
      .load_data  (eeprom_subsys_id),
      .value_q    (subsys_val[g])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ANSWER_NEXT_CYCLE: assert property (@(posedge mclk) disable iff (!reset_n || !bus_reset_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Request was not answered after exactly one cycle.");

  AST_RESET_LOCKS: assert property (@(posedge mclk) // [R2]
    !reset_n |=> write_lock == 2'b11)
    else $error("Write lock not set after global reset.");

  AST_WRITE_OPEN: assert property (@(posedge mclk) disable iff (!reset_n) // [R1]
    commit_write && hit_vendor && !req_func && !write_lock[0] && (avs_byteenable[1:0] == 2'b11) && !load_now
    |=> vendor_val[0] == $past(avs_writedata[15:0]))
    else $error("Unlocked vendor write did not take effect.");

  AST_VENDOR_READ: assert property (@(posedge mclk) disable iff (!reset_n || !bus_reset_n) // [R5]
    (bus_state_q == ssr_pkg::BUS_IDLE) && avs_read && hit_vendor && req_func
    |=> avs_readdata == {16'h0000, $past(vendor_val[1])})
    else $error("Vendor read returned the wrong value.");

  AST_LOADED: assert property (@(posedge mclk) disable iff (!reset_n) // [R3]
    load_now |=> (vendor_val[0] == $past(eeprom_subsys_vendor)) && (subsys_val[1] == $past(eeprom_subsys_id)))
    else $error("Serial memory values were not loaded.");

  AST_BIT0_ONE: assert property (@(posedge mclk) disable iff (!reset_n) // [R7]
    legacy_base_q[0])
    else $error("Legacy base bit zero is not one.");

  AST_BASE_SHARED: assert property (@(posedge mclk) disable iff (!reset_n) // [R8]
    commit_write && hit_legacy && req_func && (avs_byteenable == 4'hf)
    |=> legacy_base_q == ($past(avs_writedata) | ssr_pkg::LEGACY_BASE_FIXED))
    else $error("Legacy base write through function one not seen.");

  AST_GLOBAL_COPY: assert property (@(posedge mclk) disable iff (!reset_n) // [R9]
    commit_write && hit_syscfg && avs_byteenable[3]
    |=> sysctl_global_q == ($past(avs_writedata) & ssr_pkg::SYSCFG_GLOBAL_MASK))
    else $error("Global configuration bits not held in one copy.");

  AST_BUS_RESET_KEEPS: assert property (@(posedge mclk) disable iff (!reset_n) // [R4]
    !bus_reset_n && !load_now |=> $stable(legacy_base_q) && $stable(vendor_val[0]) && $stable(write_lock))
    else $error("Bus reset disturbed a globally reset field.");

  // The only bit without the global-reset mark must fall under a bus reset in both functions.
  AST_BUS_RESET_CLEARS: assert property (@(posedge mclk) disable iff (!reset_n) // [R4]
    !bus_reset_n |=> ((sysctl_local_q[0] & ssr_pkg::SYSCFG_BUSRST_MASK) == 32'h0000_0000)
    && ((sysctl_local_q[1] & ssr_pkg::SYSCFG_BUSRST_MASK) == 32'h0000_0000))
    else $error("Bus reset did not clear the socket bit.");

  COV_UNLOCKED_WRITE: cover property (@(posedge mclk) disable iff (!reset_n)
    commit_write && hit_subsys && !write_lock[req_func]);

  COV_LEGACY_READ: cover property (@(posedge mclk) disable iff (!reset_n)
    (bus_state_q == ssr_pkg::BUS_ANSWER) && avs_read && hit_legacy && !req_func);

  COV_LOAD: cover property (@(posedge mclk) disable iff (!reset_n)
    load_now);

  COV_DATA_HIT: cover property (@(posedge mclk) disable iff (!reset_n)
    legacy_data_hit);

endmodule
